// File: rtl/rep_timing_gen.sv
/*
 * group repetition timing generator: repetition period divider, burst
 * sequencer for master and secondary groups, code group toggle and a
 * classic wishbone register slave.
 * assumes all inputs are synchronous to ref_clk_i; ce_i freezes all state.
 */
// Overview of operation
// - forty-eight periods: six basic rates times eight specific rates
// - basic rates step by 10,000 or 20,000 us in period
// - each specific step shortens the period by exactly 100 us
// - range spans 10 groups per second up to 34.13 per second
// - period held as 13-bit count of 20 us pulse periods
// - standard spacing between pulses in a group is 1000 us
// - alternate spacing selection gives 500 us between pulses
// - single-pulse mode: two master pulses, one secondary pulse per group
// - single-pulse code groups alternate exactly as in 8-pulse operation
// - the ninth master pulse is ignored by group timing
// - counting stage toggles on each input edge, dividing by two
// - gating stage holds state until its designated event edge
// - divide count unit is one 20 us pulse period
// - master trigger marks the start of each group, secondary trigger the start of the secondary burst
`timescale 1ns/1ps
module rep_timing_gen
   import rep_timing_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic group_start_o,
   output logic master_trig_o,
   output logic second_trig_o,
   output logic pulse_o,
   output logic master_gate_o,
   output logic second_gate_o,
   output logic master_first_code_group_o,
   output logic master_second_code_group_o
);

   // =====================================================================
   // functions
   // =====================================================================
   // divide count of a selection in pulse periods
   function automatic logic [12:0] period_count(input sel_s s);
      logic [12:0] base;
      base = 13'(BASE_US_TEN / PULSE_PERIOD_US);
      unique case (s.basic)
         rate_ten: base = 13'(BASE_US_TEN / PULSE_PERIOD_US);
         rate_twelve_and_half: base = 13'(BASE_US_TWELVE / PULSE_PERIOD_US);
         rate_sixteen_two_thirds: base = 13'(BASE_US_SIXTEEN / PULSE_PERIOD_US);
         rate_twenty: base = 13'(BASE_US_TWENTY / PULSE_PERIOD_US);
         rate_twenty_five: base = 13'(BASE_US_TWENTY_FIVE / PULSE_PERIOD_US);
         rate_thirty_three: base = 13'(BASE_US_THIRTY_THREE / PULSE_PERIOD_US);
         default: base = 13'(BASE_US_TEN / PULSE_PERIOD_US);
      endcase
      return 13'(base - 13'(s.specific) * SPECIFIC_STEP_TICKS);
   endfunction : period_count

   // ticks between pulses of one burst
   function automatic logic [6:0] spacing_ticks(input logic alt);
      return alt ? SPACING_ALT_TICKS : SPACING_STD_TICKS;
   endfunction : spacing_ticks

   // pulses expected in a master or secondary burst
   function automatic logic [3:0] burst_len(input logic single, input logic second);
      if (!single) begin
         return MULTI_PULSES;
      end
      return second ? SINGLE_SECOND_PULSES : SINGLE_MASTER_PULSES;
   endfunction : burst_len

   // byte-lane merge of a wishbone write
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   // =====================================================================
   // declarations
   // =====================================================================
   logic ack_ff;
   logic [31:0] dat_ff;
   logic [31:0] ctrl_ff;
   logic [12:0] sec_delay_ff;
   logic [11:0] pre_ff;
   logic [12:0] rep_ff;
   logic [12:0] dly_ff;
   logic sec_en_ff;
   sel_s act_ff;
   seq_e state_ff;
   logic [3:0] idx_ff;
   logic [6:0] sp_ff;
   logic code_group_ff;
   logic group_start_ff;
   logic master_trig_ff;
   logic second_trig_ff;
   logic pulse_ff;
   sel_s ctrl_sel;
   logic run;
   logic tick;
   logic reload;
   logic burst_end;
   logic sec_trig_ev;
   logic pulse_ev;
   logic wr_acc;

   // =====================================================================
   // wishbone slave: ack one cycle after request, dropped the next
   // =====================================================================
   assign wr_acc = ce_i && ack_ff && wb_cyc_i && wb_stb_i && wb_we_i;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         ack_ff <= 1'b0;
      end else if (ce_i) begin
         ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
      end
   end

   // read data captured together with ack; unmapped reads give zero
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         dat_ff <= 32'h0000_0000;
      end else if (ce_i && wb_cyc_i && wb_stb_i && !ack_ff) begin
         unique case (wb_adr_i)
            CTRL_ADR: dat_ff <= ctrl_ff;
            SEC_DELAY_ADR: dat_ff <= {19'h00000, sec_delay_ff};
            STATUS_ADR: dat_ff <= {14'h0000, state_ff, code_group_ff, 2'h0,
                                   period_count(act_ff)};
            COUNT_ADR: dat_ff <= {19'h00000, rep_ff};
            default: dat_ff <= 32'h0000_0000;
         endcase
      end
   end

   // writes land on the edge where the master samples ack
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         ctrl_ff <= CTRL_RST;
         sec_delay_ff <= SEC_DELAY_RST;
      end else if (wr_acc) begin
         if (wb_adr_i == CTRL_ADR) begin
            ctrl_ff <= merge(ctrl_ff, wb_dat_i, wb_sel_i) & CTRL_MASK;
         end
         if (wb_adr_i == SEC_DELAY_ADR) begin
            sec_delay_ff <= 13'(merge({19'h00000, sec_delay_ff}, wb_dat_i, wb_sel_i));
         end
      end
   end

   assign ctrl_sel = '{basic: basic_e'(ctrl_ff[CTRL_BASIC_LSB +: 3]),
                       specific: ctrl_ff[CTRL_SPECIFIC_LSB +: 3],
                       alt_spacing: ctrl_ff[CTRL_ALT_BIT],
                       single_pulse: ctrl_ff[CTRL_SINGLE_BIT]};
   assign run = ctrl_ff[CTRL_RUN_BIT];

   // =====================================================================
   // pulse period prescaler
   // =====================================================================
   assign tick = ce_i && (pre_ff == 12'(TICK_CYCLES_P - 1));

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         pre_ff <= 12'h000;
      end else if (ce_i) begin
         pre_ff <= tick ? 12'h000 : 12'(pre_ff + 12'h001);
      end
   end

   // =====================================================================
   // repetition divider
   // =====================================================================
   assign reload = tick && run && (rep_ff <= 13'h0001);

   // load the selected count at every boundary and latch the selection
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         rep_ff <= 13'h0000;
         act_ff <= '{basic: rate_ten, specific: 3'h0, alt_spacing: 1'b0,
                     single_pulse: 1'b0};
      end else if (ce_i) begin
         if (!run) begin
            rep_ff <= 13'h0000;
         end else if (reload) begin
            rep_ff <= period_count(ctrl_sel);
            act_ff <= ctrl_sel;
         end else if (tick) begin
            rep_ff <= 13'(rep_ff - 13'h0001);
         end
      end
   end

   // code group toggle divides the group rate by two
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         code_group_ff <= 1'b0;
      end else if (ce_i && reload) begin
         code_group_ff <= !code_group_ff;
      end
   end

   // secondary delay from group start, in pulse periods
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         dly_ff <= 13'h0000;
         sec_en_ff <= 1'b0;
      end else if (ce_i) begin
         if (reload) begin
            dly_ff <= sec_delay_ff;
            sec_en_ff <= (sec_delay_ff != 13'h0000);
         end else if (tick && dly_ff != 13'h0000) begin
            dly_ff <= 13'(dly_ff - 13'h0001);
         end
      end
   end

   // =====================================================================
   // burst sequencer
   // =====================================================================
   assign burst_end = (sp_ff == 7'h01) &&
                      (idx_ff == burst_len(act_ff.single_pulse, state_ff == SEQ_SECOND));
   assign sec_trig_ev = tick && !reload && (state_ff == SEQ_WAIT) &&
                        (dly_ff == 13'h0000) && sec_en_ff;
   assign pulse_ev = reload || sec_trig_ev ||
                     (tick && (state_ff == SEQ_MASTER || state_ff == SEQ_SECOND) &&
                      sp_ff == 7'h01 && !burst_end);

   // gate stages move only on a pulse-period tick, a group start, or when run is cleared
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_ff <= SEQ_IDLE;
         idx_ff <= 4'h0;
         sp_ff <= 7'h00;
      end else if (ce_i) begin
         if (!run) begin
            state_ff <= SEQ_IDLE;
         end else if (reload) begin
            state_ff <= SEQ_MASTER;
            idx_ff <= 4'h1;
            sp_ff <= spacing_ticks(ctrl_sel.alt_spacing);
         end else if (tick) begin
            unique case (state_ff)
               SEQ_IDLE: state_ff <= SEQ_IDLE;
               SEQ_MASTER, SEQ_SECOND: begin
                  if (burst_end) begin
                     // ninth master pulse is never counted
                     state_ff <= (state_ff == SEQ_MASTER) ? SEQ_WAIT : SEQ_IDLE;
                  end else if (sp_ff == 7'h01) begin
                     idx_ff <= 4'(idx_ff + 4'h1);
                     sp_ff <= spacing_ticks(act_ff.alt_spacing);
                  end else begin
                     sp_ff <= 7'(sp_ff - 7'h01);
                  end
               end
               SEQ_WAIT: begin
                  // a delay that runs out before the master burst ends just starts the burst late; stations avoid overlap
                  if (dly_ff == 13'h0000) begin
                     state_ff <= sec_en_ff ? SEQ_SECOND : SEQ_IDLE;
                     idx_ff <= 4'h1;
                     sp_ff <= spacing_ticks(act_ff.alt_spacing);
                  end
               end
            endcase
         end
      end
   end

   // registered one-cycle strobes
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         group_start_ff <= 1'b0;
         master_trig_ff <= 1'b0;
         second_trig_ff <= 1'b0;
         pulse_ff <= 1'b0;
      end else if (ce_i) begin
         group_start_ff <= reload;
         master_trig_ff <= reload;
         second_trig_ff <= sec_trig_ev;
         pulse_ff <= pulse_ev;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
   assign group_start_o = group_start_ff;
   assign master_trig_o = master_trig_ff;
   assign second_trig_o = second_trig_ff;
   assign pulse_o = pulse_ff;
   assign master_gate_o = (state_ff == SEQ_MASTER);
   assign second_gate_o = (state_ff == SEQ_SECOND);
   assign master_first_code_group_o = !code_group_ff;
   assign master_second_code_group_o = code_group_ff;

   // =====================================================================
   // checking helpers and assertions
   // =====================================================================
   logic [12:0] gap_ff;
   logic [12:0] gap_last_ff;
   logic [12:0] per_ff;
   logic [12:0] per_last_ff;
   logic [12:0] old_cnt_ff;
   logic seen_ff;
   logic [3:0] burst_ff;

   // ticks between pulses, ticks per period and pulses per burst
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         gap_ff <= 13'h0000;
         gap_last_ff <= 13'h0000;
         per_ff <= 13'h0000;
         per_last_ff <= 13'h0000;
         old_cnt_ff <= 13'h0000;
         seen_ff <= 1'b0;
         burst_ff <= 4'h0;
      end else if (ce_i) begin
         if (pulse_ev) begin
            gap_last_ff <= 13'(gap_ff + 13'h0001);
            gap_ff <= 13'h0000;
         end else if (tick) begin
            gap_ff <= 13'(gap_ff + 13'h0001);
         end
         if (reload) begin
            per_last_ff <= 13'(per_ff + 13'h0001);
            per_ff <= 13'h0000;
            old_cnt_ff <= period_count(act_ff);
         end else if (tick) begin
            per_ff <= 13'(per_ff + 13'h0001);
         end
         seen_ff <= run && (seen_ff || reload);
         if (reload || sec_trig_ev) begin
            burst_ff <= 4'h1;
         end else if (pulse_ev) begin
            burst_ff <= 4'(burst_ff + 4'h1);
         end
      end
   end

   property p_load_count;
      @(posedge ref_clk_i) disable iff (reset_i)
      group_start_ff |-> rep_ff == period_count(act_ff);
   endproperty
   a_load_count: assert property (p_load_count) else $error("reload count wrong");

   property p_specific_step;
      @(posedge ref_clk_i) disable iff (reset_i)
      (act_ff.specific != 3'h0) |->
         13'(period_count(act_ff) + SPECIFIC_STEP_TICKS) ==
         period_count('{basic: act_ff.basic, specific: 3'(act_ff.specific - 3'h1),
                        alt_spacing: 1'b0, single_pulse: 1'b0});
   endproperty
   a_specific_step: assert property (p_specific_step) else $error("specific step wrong");

   property p_range;
      @(posedge ref_clk_i) disable iff (reset_i)
      group_start_ff |-> rep_ff >= MIN_PERIOD_TICKS && rep_ff <= MAX_PERIOD_TICKS;
   endproperty
   a_range: assert property (p_range) else $error("period out of range");

   property p_period_length;
      @(posedge ref_clk_i) disable iff (reset_i)
      $rose(group_start_ff) && $past(seen_ff) |-> per_last_ff == old_cnt_ff;
   endproperty
   a_period_length: assert property (p_period_length) else $error("period length wrong");

   property p_spacing;
      @(posedge ref_clk_i) disable iff (reset_i)
      $rose(pulse_ff) && !master_trig_ff && !second_trig_ff |->
         gap_last_ff == 13'(spacing_ticks(act_ff.alt_spacing));
   endproperty
   a_spacing: assert property (p_spacing) else $error("pulse spacing wrong");

   property p_burst_len;
      @(posedge ref_clk_i) disable iff (reset_i)
      ($past(state_ff) == SEQ_MASTER && state_ff == SEQ_WAIT) |->
         burst_ff == burst_len(act_ff.single_pulse, 1'b0);
   endproperty
   a_burst_len: assert property (p_burst_len) else $error("master burst length wrong");

   property p_trig_pulse;
      @(posedge ref_clk_i) disable iff (reset_i)
      $rose(master_trig_ff) |-> pulse_ff && master_gate_o && idx_ff == 4'h1;
   endproperty
   a_trig_pulse: assert property (p_trig_pulse) else $error("trigger without pulse");

   property p_toggle;
      @(posedge ref_clk_i) disable iff (reset_i)
      $rose(group_start_ff) |-> code_group_ff != $past(code_group_ff);
   endproperty
   a_toggle: assert property (p_toggle) else $error("code group did not toggle");

   // the edge right after a reset compares against pre-reset values, so skip it
   property p_sel_boundary;
      @(posedge ref_clk_i) disable iff (reset_i)
      !$past(reset_i) && (act_ff != $past(act_ff)) |-> group_start_ff;
   endproperty
   a_sel_boundary: assert property (p_sel_boundary) else $error("selection changed midway");

   property p_gate_event;
      @(posedge ref_clk_i) disable iff (reset_i)
      !$past(reset_i) && (state_ff != $past(state_ff)) |-> $past(tick) || !$past(run);
   endproperty
   a_gate_event: assert property (p_gate_event) else $error("gate moved off event");

   property p_ack_drop;
      @(posedge ref_clk_i) disable iff (reset_i)
      ack_ff && $past(ce_i) |=> !ack_ff || !$past(ce_i);
   endproperty
   a_ack_drop: assert property (p_ack_drop) else $error("ack held too long");

   c_group: cover property (@(posedge ref_clk_i) disable iff (reset_i)
                            $rose(group_start_ff) && seen_ff);
   c_second: cover property (@(posedge ref_clk_i) disable iff (reset_i) $rose(second_trig_ff));
   c_alt: cover property (@(posedge ref_clk_i) disable iff (reset_i)
                          $rose(pulse_ff) && act_ff.alt_spacing && !master_trig_ff);
   c_single: cover property (@(posedge ref_clk_i) disable iff (reset_i)
                             state_ff == SEQ_WAIT && act_ff.single_pulse);

endmodule : rep_timing_gen

// File: rtl/rep_timing_pkg.sv
/*
 * constants, types and register map of the group repetition timing generator.
 * assumes a 200 mhz reference clock and a 20 us pulse period.
 */
package rep_timing_pkg;

   // =====================================================================
   // clock and pulse period
   // =====================================================================
   localparam int CLK_MHZ = 200;
   localparam int PULSE_PERIOD_US = 20;
   localparam int TICK_CYCLES = PULSE_PERIOD_US * CLK_MHZ;

   // =====================================================================
   // repetition periods and pulse spacing
   // =====================================================================
   localparam int COUNT_W = 13;
   localparam int SPECIFIC_STEP_US = 100;
   localparam logic [12:0] SPECIFIC_STEP_TICKS = 13'(SPECIFIC_STEP_US / PULSE_PERIOD_US);
   localparam int BASE_US_TEN = 100000;
   localparam int BASE_US_TWELVE = 80000;
   localparam int BASE_US_SIXTEEN = 60000;
   localparam int BASE_US_TWENTY = 50000;
   localparam int BASE_US_TWENTY_FIVE = 40000;
   localparam int BASE_US_THIRTY_THREE = 30000;
   localparam logic [12:0] MIN_PERIOD_TICKS = 13'h05B9;
   localparam logic [12:0] MAX_PERIOD_TICKS = 13'h1388;
   localparam int SPACING_STD_US = 1000;
   localparam int SPACING_ALT_US = 500;
   localparam logic [6:0] SPACING_STD_TICKS = 7'(SPACING_STD_US / PULSE_PERIOD_US);
   localparam logic [6:0] SPACING_ALT_TICKS = 7'(SPACING_ALT_US / PULSE_PERIOD_US);
   localparam logic [3:0] MULTI_PULSES = 4'h8;
   localparam logic [3:0] SINGLE_MASTER_PULSES = 4'h2;
   localparam logic [3:0] SINGLE_SECOND_PULSES = 4'h1;

   // =====================================================================
   // register map
   // =====================================================================
   localparam logic [7:0] CTRL_ADR = 8'h00;
   localparam logic [7:0] SEC_DELAY_ADR = 8'h04;
   localparam logic [7:0] STATUS_ADR = 8'h08;
   localparam logic [7:0] COUNT_ADR = 8'h0C;
   localparam int CTRL_BASIC_LSB = 0;
   localparam int CTRL_SPECIFIC_LSB = 4;
   localparam int CTRL_ALT_BIT = 8;
   localparam int CTRL_SINGLE_BIT = 9;
   localparam int CTRL_RUN_BIT = 10;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0777;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [12:0] SEC_DELAY_RST = 13'h0000;
   localparam int STATUS_CODE_BIT = 15;
   localparam int STATUS_STATE_LSB = 16;

   // six basic rates; codes 6 and 7 fall back to the slowest
   typedef enum logic [2:0] {
      rate_ten = 3'h0,
      rate_twelve_and_half = 3'h1,
      rate_sixteen_two_thirds = 3'h2,
      rate_twenty = 3'h3,
      rate_twenty_five = 3'h4,
      rate_thirty_three = 3'h5
   } basic_e;

   // burst sequencer, gray coded along idle-master-wait-second
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_MASTER = 2'b01,
      SEQ_WAIT = 2'b11,
      SEQ_SECOND = 2'b10
   } seq_e;

   // one rate and spacing selection
   typedef struct packed {
      basic_e basic;
      logic [2:0] specific;
      logic alt_spacing;
      logic single_pulse;
   } sel_s;

endpackage : rep_timing_pkg

// File: test/chain_model.sv
/*
 * station chain observer: tallies master and secondary pulses per group
 * and flags any overlap of the master and secondary intervals.
 * assumes the generator's registered outputs, sampled on ref_clk_i.
 */
`timescale 1ns/1ps
module chain_model (
   input wire logic ref_clk_i,
   input wire logic group_start_i,
   input wire logic pulse_i,
   input wire logic master_gate_i,
   input wire logic second_gate_i,
   output int m_cnt_o,
   output int s_cnt_o,
   output logic clash_o
);
   int m_ff = 0;
   int s_ff = 0;
   logic clash_ff = 1'b0;
   assign clash_o = clash_ff;
   // =============================================
   // per group tally; secondaries never overlap the master
   always @(posedge ref_clk_i) begin
      // both intervals at once, or a pulse outside both, is a clash
      clash_ff <= clash_ff | (master_gate_i === 1'b1 && second_gate_i === 1'b1) |
                  (pulse_i === 1'b1 && !(master_gate_i === 1'b1 || second_gate_i === 1'b1));
      if (group_start_i) begin
         m_cnt_o <= m_ff;
         s_cnt_o <= s_ff;
         m_ff <= 1;
         s_ff <= 0;
      end else begin
         m_ff <= m_ff + int'(pulse_i & master_gate_i);
         s_ff <= s_ff + int'(pulse_i & !master_gate_i);
      end
   end
endmodule : chain_model

// File: test/tb_rep_timing_gen.sv
/*
 * bench for the repetition timing generator: rate table, spacing, modes,
 * boundary changes and reset. assumes a short tick to keep the run brief.
 */
`timescale 1ns/1ps
module tb_rep_timing_gen;
   import rep_timing_pkg::*;
   localparam int TK = 4;
   logic ref_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic req = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rd_bus, rdat;
   logic gs, mt, st, pl, mg, sg, c1, c2, ack, clash, c1v;
   int fails = 0;
   int check_count = 0;
   int cyc_n = 0;
   int stamp, t0, m_cnt, s_cnt;
   // rows: base period ticks per basic code, codes 6 and 7 act as slowest
   logic [12:0] base_ticks [8] = '{13'h1388, 13'h0FA0, 13'h0BB8, 13'h09C4,
      13'h07D0, 13'h05DC, 13'h1388, 13'h1388};
   logic [31:0] mode_bits [3] = '{32'h000, 32'h100, 32'h200};
   int m_exp [3] = '{8, 8, 2};
   int s_exp [3] = '{8, 8, 1};
   int sp_exp [3] = '{50, 25, 50};
   // =============================================
   // clock, cycle count, design and partner
   always #2.5 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) cyc_n <= cyc_n + 1;
   rep_timing_gen #(.TICK_CYCLES_P(TK)) rep_timing_gen_i (.ref_clk_i(ref_clk_i),
      .reset_i(reset_i), .ce_i(1'b1), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rd_bus),
      .wb_ack_o(ack), .group_start_o(gs), .master_trig_o(mt), .second_trig_o(st),
      .pulse_o(pl), .master_gate_o(mg), .second_gate_o(sg),
      .master_first_code_group_o(c1), .master_second_code_group_o(c2));
   chain_model chain_model_i (.ref_clk_i(ref_clk_i), .group_start_i(gs), .pulse_i(pl),
      .master_gate_i(mg), .second_gate_i(sg), .m_cnt_o(m_cnt), .s_cnt_o(s_cnt),
      .clash_o(clash));
   // =============================================
   // compare, bus and wait tasks
   task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk_v
   task automatic chk_n(input int got, input int exp);
      check_count++;
      if (got != exp) begin
         fails++;
         $display("wrong value at %0t: got %0d want %0d", $time, got, exp);
      end
   endtask : chk_n
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge ref_clk_i);
      req <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge ref_clk_i); while (ack !== 1'b1 && ++k < 50);
      if (k >= 50) fails++;
      rdat = rd_bus;
      req <= 1'b0;
   endtask : wb
   task automatic wait_for(input logic pul);
      int k;
      k = 0;
      do @(posedge ref_clk_i); while ((pul ? pl : gs) !== 1'b1 && ++k < 30000);
      if (k >= 30000) fails++;
      stamp = cyc_n;
   endtask : wait_for
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   // =============================================
   // watchdog
   initial begin
      repeat (90000) @(posedge ref_clk_i);
      fails++;
      $display("wrong value at %0t: watchdog expired", $time);
      close_out();
   end
   // =============================================
   // main sequence
   initial begin
      repeat (8) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      for (int b = 0; b < 8; b++) begin
         for (int s = 0; s < 8; s++) begin
            wb(1'b1, CTRL_ADR, 32'h0);
            wb(1'b1, CTRL_ADR, 32'h400 | 32'(s << 4) | 32'(b));
            wait_for(1'b0);
            wb(1'b0, STATUS_ADR, 32'h0);
            chk_v(32'(rdat[12:0]), 32'(base_ticks[b] - 13'(5 * s)));
         end
      end
      $display("test rate table done");
      wb(1'b1, 8'h10, 32'hFFFF_FFFF);
      wb(1'b0, 8'h10, 32'h0);
      chk_v(rdat, 32'h0);
      wb(1'b1, SEC_DELAY_ADR, 32'h0000_01F4);
      for (int m = 0; m < 3; m++) begin
         wb(1'b1, CTRL_ADR, 32'h0);
         wb(1'b1, CTRL_ADR, 32'h475 | mode_bits[m]);
         wait_for(1'b0);
         t0 = stamp;
         c1v = c1;
         chk_v(32'(mt), 32'h1);
         wait_for(1'b1);
         chk_n(stamp - t0, sp_exp[m] * TK);
         // selection changed mid-period, must wait for the boundary
         wb(1'b1, CTRL_ADR, 32'h404 | mode_bits[m]);
         wait_for(1'b0);
         chk_n(stamp - t0, 1465 * TK);
         chk_v(32'(c1), 32'(!c1v));
         chk_v(32'(c2), 32'(!c1));
         t0 = stamp;
         wait_for(1'b0);
         chk_n(stamp - t0, 2000 * TK);
         // the tally of the period just ended lands one edge after group start
         @(posedge ref_clk_i);
         chk_n(m_cnt, m_exp[m]);
         chk_n(s_cnt, s_exp[m]);
         $display("test mode %0d done", m);
      end
      chk_v(32'(clash), 32'h0);
      @(posedge ref_clk_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      chk_v(32'({gs, mt, st, pl, mg, sg, c1, c2, ack}), 32'h4);
      reset_i <= 1'b0;
      wb(1'b0, CTRL_ADR, 32'h0);
      chk_v(rdat, 32'h0);
      $display("test reset done");
      close_out();
   end
endmodule : tb_rep_timing_gen
